// file: mfs_monitor.sv
// motor fault and status supervision with apb register access
//
// Our own choice: the APB slave port.
`include "mfs_defines.svh"
`default_nettype none

// ************************************************************
// Overview of operation
// - in-position asserts after condition holds settle_sample_count samples, default 3
// - position condition: target distance below the tolerance window
// - bit 0 set when thermal energy exceeds its limit
// - bit 1 set on following deviation above max, never when max zero
// - bit 2 set on profile deviation above max, never when max zero
// - bit 3 set when dump resistor is dangerously hot
// - bit 4 shows settled position, or reached velocity in velocity mode
// - bit 5 set when signed velocity falls between samples
// - bit 6 set when signed velocity rises between samples
// - bit 7 set when position passes either soft limit
// - bit 8 set when drive temperature exceeds its limit
// - bit 9 undervoltage fault only while policy bit 0 is one
// - bit 10 live undervoltage, clears after one second with hysteresis
// - bit 11 set when bus voltage exceeds overvoltage threshold
// - bit 12 phase overcurrent, cleared only by reset
// - bit 13 set when sixteen-sample speed average exceeds limit
// - bit 14 override keeps motion allowed, self-clears back in range
// - bit 15 encoder fault, cleared only by reset
// - bit 16 is unused and always zero
// - bit 17 control supply below 12 V, cleared only by reset
// ************************************************************

module mfs_monitor
    import mfs_pkg::*;
#(
    parameter int UV_HOLD_CYC = `MFS_UV_HOLD_CYC,
    parameter int AVG_DEPTH   = `MFS_AVG_DEPTH
) (
    // clock and reset
    input  wire logic              CLOCK,
    input  wire logic              RESETN,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [`MFS_AW-1:0] PADDR,
    input  wire logic [31:0]       PWDATA,
    output logic      [31:0]       PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // measurements from the motion controller
    input  wire logic              SAMPLE,
    input  wire mfs_meas_t         MEAS,
    // asynchronous fault pins
    input  wire logic              AC_MISSING,
    input  wire logic              PHASE_OVERCURRENT,
    input  wire logic              ENCODER_FAULT,
    // status outputs
    output logic      [31:0]       STATUS,
    output logic                   FAULT,
    output logic                   MOTION_INHIBIT
);

    typedef struct packed {
        mfs_cfg_t               cfg;
        logic [31:0]            status;
        logic [31:0]            settle_cnt;
        logic signed [31:0]     prev_vel;
        logic [`MFS_UV_TW-1:0]  uv_timer;
        logic [31:0]            prdata;
        logic                   pready;
        logic                   pslverr;
        logic                   fault;
        logic                   inhibit;
    } mfs_state_t;

    mfs_state_t         st;
    mfs_state_t         next_st;
    logic [2:0]         pins;
    logic [31:0]        avg_speed;
    logic [7:0]         idx;
    logic               acc;
    logic               wr;
    logic               clear;
    logic [31:0]        set;
    logic [31:0]        keep;
    logic               cond;
    logic               outside;
    logic               uv_cond;
    logic               uv_high;
    logic [32:0]        pos_err;
    logic [32:0]        vel_err;

    // ************************************************************
    // helpers
    // ************************************************************
    function automatic logic mapped(input logic [7:0] i);
        return i inside {[`MFS_IDX_CTRL:`MFS_IDX_SPDLIM], `MFS_IDX_SETTLE, `MFS_IDX_STATUS};
    endfunction

    function automatic logic [32:0] mag33(input logic signed [32:0] x);
        return x[32] ? 33'(-x) : 33'(x);
    endfunction

    function automatic logic signed [32:0] diff33(input logic signed [31:0] a,
                                                  input logic signed [31:0] b);
        return {a[31], a} - {b[31], b};
    endfunction

    // ************************************************************
    // submodules
    // ************************************************************
    mfs_sync #(
        .N (3)
    ) u_sync (
        .clk   (CLOCK),
        .rst_n (RESETN),
        .d     ({AC_MISSING, PHASE_OVERCURRENT, ENCODER_FAULT}),
        .q     (pins)
    );

    mfs_speed_avg #(
        .W     (32),
        .DEPTH (AVG_DEPTH)
    ) u_avg (
        .clk    (CLOCK),
        .rst_n  (RESETN),
        .sample (SAMPLE),
        .vel    (MEAS.measured_velocity),
        .avg    (avg_speed)
    );

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        next_st = st;
        idx     = PADDR[9:2];
        acc     = PSEL && PENABLE && !st.pready;
        wr      = PSEL && PENABLE && PWRITE && st.pready && mapped(idx);
        clear   = wr && idx == `MFS_IDX_CTRL && PWDATA[`MFS_C_CLEAR];
        set     = '0;
        pos_err = mag33(diff33(MEAS.position, MEAS.target_position));
        vel_err = mag33(diff33(MEAS.measured_velocity, MEAS.target_velocity));
        outside = MEAS.position < st.cfg.plim_lo || MEAS.position > st.cfg.plim_hi;
        uv_cond = pins[2] || MEAS.bus_voltage < st.cfg.uv_cutoff;
        uv_high = 19'(MEAS.bus_voltage) * `MFS_UV_HYS_DEN >
                  19'(st.cfg.uv_cutoff) * `MFS_UV_HYS_NUM;
        // the settle condition depends on the operating mode
        cond    = st.cfg.vel_mode ? vel_err < {1'b0, st.cfg.position_tolerance_window}
                                  : pos_err < {1'b0, st.cfg.position_tolerance_window};

        // apb answer one cycle into the access phase
        next_st.pready  = acc;
        next_st.pslverr = acc && !mapped(idx);
        if (acc) begin
            unique case (idx)
                `MFS_IDX_CTRL:    next_st.prdata = 32'(st.cfg.vel_mode) << `MFS_C_VMODE;
                `MFS_IDX_THERMAL: next_st.prdata = 32'(st.cfg.thermal_energy_limit);
                `MFS_IDX_FLWMAX:  next_st.prdata = st.cfg.following_deviation_max;
                `MFS_IDX_PRFMAX:  next_st.prdata = st.cfg.profile_deviation_max;
                `MFS_IDX_TEMPLIM: next_st.prdata = 32'(st.cfg.temperature_limit);
                `MFS_IDX_PLIMLO:  next_st.prdata = st.cfg.plim_lo;
                `MFS_IDX_PLIMHI:  next_st.prdata = st.cfg.plim_hi;
                `MFS_IDX_UVPOL:   next_st.prdata = st.cfg.undervoltage_policy;
                `MFS_IDX_WINDOW:  next_st.prdata = st.cfg.position_tolerance_window;
                `MFS_IDX_OVLIM:   next_st.prdata = 32'(st.cfg.ov_limit);
                `MFS_IDX_UVCUT:   next_st.prdata = 32'(st.cfg.uv_cutoff);
                `MFS_IDX_SPDLIM:  next_st.prdata = st.cfg.speed_limit;
                `MFS_IDX_SETTLE:  next_st.prdata = st.cfg.settle_sample_count;
                `MFS_IDX_STATUS:  next_st.prdata = st.status;
                default:          next_st.prdata = '0;
            endcase
        end

        // configuration writes take effect at the sampled pready edge
        if (wr) begin
            unique case (idx)
                `MFS_IDX_CTRL:    next_st.cfg.vel_mode = PWDATA[`MFS_C_VMODE];
                `MFS_IDX_THERMAL: next_st.cfg.thermal_energy_limit = PWDATA[15:0];
                `MFS_IDX_FLWMAX:  next_st.cfg.following_deviation_max = PWDATA;
                `MFS_IDX_PRFMAX:  next_st.cfg.profile_deviation_max = PWDATA;
                `MFS_IDX_TEMPLIM: next_st.cfg.temperature_limit = PWDATA[15:0];
                `MFS_IDX_PLIMLO:  next_st.cfg.plim_lo = PWDATA;
                `MFS_IDX_PLIMHI:  next_st.cfg.plim_hi = PWDATA;
                `MFS_IDX_UVPOL:   next_st.cfg.undervoltage_policy = PWDATA;
                `MFS_IDX_WINDOW:  next_st.cfg.position_tolerance_window = PWDATA;
                `MFS_IDX_OVLIM:   next_st.cfg.ov_limit = PWDATA[15:0];
                `MFS_IDX_UVCUT:   next_st.cfg.uv_cutoff = PWDATA[15:0];
                `MFS_IDX_SPDLIM:  next_st.cfg.speed_limit = PWDATA;
                `MFS_IDX_SETTLE:  next_st.cfg.settle_sample_count = PWDATA;
                default:          next_st.cfg = st.cfg;
            endcase
        end

        // fault events from the sampled measurements and from the synchronised fault pins
        if (SAMPLE) begin
            set[`MFS_B_THERMAL] = MEAS.motor_thermal_energy > st.cfg.thermal_energy_limit;
            set[`MFS_B_FOLLOW]  = st.cfg.following_deviation_max != '0 &&
                mag33(33'(MEAS.following_deviation)) >
                {1'b0, st.cfg.following_deviation_max};
            set[`MFS_B_PROFILE] = st.cfg.profile_deviation_max != '0 &&
                mag33(33'(MEAS.profile_deviation)) >
                {1'b0, st.cfg.profile_deviation_max};
            set[`MFS_B_DUMP]    = MEAS.dump_resistor_hot;
            set[`MFS_B_SOFTLIM] = outside;
            set[`MFS_B_TEMP]    = MEAS.drive_temperature > st.cfg.temperature_limit;
            set[`MFS_B_UVFAULT] = uv_cond && st.cfg.undervoltage_policy[`MFS_P_UVENABLE];
            set[`MFS_B_OVER_V]  = MEAS.bus_voltage > st.cfg.ov_limit;
            set[`MFS_B_SPEED]   = avg_speed > st.cfg.speed_limit;
            set[`MFS_B_CTRL_SUP] = MEAS.control_voltage_mv < `MFS_CTRL_MIN_MV;
        end
        set[`MFS_B_PHASE_I] = pins[1];
        set[`MFS_B_ENCODER] = pins[0];

        // sticky errors, a new event wins over a clear in the same cycle
        keep = st.status & (clear ? `MFS_NOCLR_MASK : `MFS_ERR_MASK);
        next_st.status = (keep | set) & `MFS_ERR_MASK;

        // settle counter and live motion flags
        if (SAMPLE) begin
            next_st.prev_vel = MEAS.measured_velocity;
            if (!cond) begin
                next_st.settle_cnt = '0;
            end else if (st.settle_cnt < st.cfg.settle_sample_count) begin
                next_st.settle_cnt = st.settle_cnt + 32'h1;
            end
        end
        next_st.status[`MFS_B_INPOS] = cond &&
            next_st.settle_cnt >= st.cfg.settle_sample_count;
        next_st.status[`MFS_B_ACCEL] = SAMPLE ? MEAS.measured_velocity < st.prev_vel
                                               : st.status[`MFS_B_ACCEL];
        next_st.status[`MFS_B_DECEL] = SAMPLE ? MEAS.measured_velocity > st.prev_vel
                                               : st.status[`MFS_B_DECEL];

        // live undervoltage with hold-off and hysteresis
        next_st.status[`MFS_B_UVLIVE] = st.status[`MFS_B_UVLIVE];
        next_st.uv_timer = '0;
        if (uv_cond) begin
            next_st.status[`MFS_B_UVLIVE] = 1'b1;
        end else if (st.status[`MFS_B_UVLIVE] && uv_high) begin
            next_st.uv_timer = `MFS_UV_TW'(st.uv_timer + 1'b1);
            if (st.uv_timer == `MFS_UV_TW'(UV_HOLD_CYC - 1)) begin
                next_st.status[`MFS_B_UVLIVE] = 1'b0;
                next_st.uv_timer = '0;
            end
        end

        // override is set by software and dropped back inside the range
        next_st.status[`MFS_B_OVERRIDE] = st.status[`MFS_B_OVERRIDE] && outside;
        if (wr && idx == `MFS_IDX_STATUS && PWDATA[`MFS_B_OVERRIDE]) begin
            next_st.status[`MFS_B_OVERRIDE] = 1'b1;
        end
        next_st.status[`MFS_B_LEGACY] = 1'b0;

        next_st.fault   = |(next_st.status & `MFS_ERR_MASK);
        next_st.inhibit = outside && !next_st.status[`MFS_B_OVERRIDE];
    end

    // ************************************************************
    // state register
    // ************************************************************
    always_ff @(posedge CLOCK or negedge RESETN) begin
        if (!RESETN) begin
            st <= '0;
            st.cfg.settle_sample_count <= `MFS_RST_SETTLE;
            st.cfg.position_tolerance_window <= `MFS_RST_WINDOW;
            st.cfg.ov_limit <= `MFS_RST_OVLIM;
            st.cfg.uv_cutoff <= `MFS_RST_UVCUT;
            st.cfg.speed_limit <= `MFS_RST_SPDLIM;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from the state register
    assign PRDATA         = st.prdata;
    assign PREADY         = st.pready;
    assign PSLVERR        = st.pslverr;
    assign STATUS         = st.status;
    assign FAULT          = st.fault;
    assign MOTION_INHIBIT = st.inhibit;

    // ************************************************************
    // assertions
    // ************************************************************
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (!RESETN);

    sequence s_clear_write;
        PSEL && PENABLE && PWRITE && PREADY && idx == `MFS_IDX_CTRL && PWDATA[`MFS_C_CLEAR];
    endsequence

    sequence s_override_write;
        PSEL && PENABLE && PWRITE && PREADY && idx == `MFS_IDX_STATUS &&
        PWDATA[`MFS_B_OVERRIDE];
    endsequence

    settle_count_a: assert property ($rose(STATUS[`MFS_B_INPOS]) |->
        st.settle_cnt >= st.cfg.settle_sample_count)
        else $error("in-position rose before the settle count");
    thermal_set_a: assert property (SAMPLE &&
        MEAS.motor_thermal_energy > st.cfg.thermal_energy_limit
        |=> STATUS[`MFS_B_THERMAL])
        else $error("thermal fault missed");
    follow_zero_a: assert property ($rose(STATUS[`MFS_B_FOLLOW]) |->
        $past(st.cfg.following_deviation_max) != '0)
        else $error("following fault with zero maximum");
    profile_zero_a: assert property ($rose(STATUS[`MFS_B_PROFILE]) |->
        $past(st.cfg.profile_deviation_max) != '0)
        else $error("profile fault with zero maximum");
    accel_flag_a: assert property (SAMPLE && MEAS.measured_velocity < st.prev_vel
        |=> STATUS[`MFS_B_ACCEL] && !STATUS[`MFS_B_DECEL])
        else $error("accelerating flag wrong");
    uv_policy_a: assert property ($rose(STATUS[`MFS_B_UVFAULT]) |->
        $past(st.cfg.undervoltage_policy[`MFS_P_UVENABLE]))
        else $error("undervoltage fault while policy off");
    uv_live_a: assert property (uv_cond |=> STATUS[`MFS_B_UVLIVE]
        ##0 st.uv_timer == '0)
        else $error("live undervoltage not shown");
    phase_hold_a: assert property (STATUS[`MFS_B_PHASE_I] |=>
        STATUS[`MFS_B_PHASE_I] [*2])
        else $error("phase overcurrent fault dropped");
    encoder_hold_a: assert property (s_clear_write and STATUS[`MFS_B_ENCODER]
        |=> STATUS[`MFS_B_ENCODER])
        else $error("encoder fault cleared by software");
    legacy_zero_a: assert property (!STATUS[`MFS_B_LEGACY])
        else $error("unused status bit set");
    override_set_a: assert property (s_override_write |=>
        STATUS[`MFS_B_OVERRIDE] ##0 !MOTION_INHIBIT)
        else $error("override write not taken");
    sticky_keep_a: assert property (STATUS[`MFS_B_TEMP] && !clear
        |=> STATUS[`MFS_B_TEMP])
        else $error("temperature fault lost without a clear");
    clear_works_a: assert property (s_clear_write ##0 !SAMPLE
        |=> !STATUS[`MFS_B_THERMAL] && !STATUS[`MFS_B_OVER_V])
        else $error("clear errors left a fault set");
endmodule

`default_nettype wire

// file: mfs_defines.svh
// constants for the motor fault and status monitor
`ifndef MFS_DEFINES_SVH
`define MFS_DEFINES_SVH

// ************************************************************
// register indices, byte address is four times the index
// ************************************************************
`define MFS_AW           12
`define MFS_IDX_CTRL     8'h10
`define MFS_IDX_THERMAL  8'h11
`define MFS_IDX_FLWMAX   8'h12
`define MFS_IDX_PRFMAX   8'h13
`define MFS_IDX_TEMPLIM  8'h14
`define MFS_IDX_PLIMLO   8'h15
`define MFS_IDX_PLIMHI   8'h16
`define MFS_IDX_UVPOL    8'h17
`define MFS_IDX_WINDOW   8'h18
`define MFS_IDX_OVLIM    8'h19
`define MFS_IDX_UVCUT    8'h1a
`define MFS_IDX_SPDLIM   8'h1b
`define MFS_IDX_SETTLE   8'h22
`define MFS_IDX_STATUS   8'h23

// ************************************************************
// status word bit positions
// ************************************************************
`define MFS_B_THERMAL    0
`define MFS_B_FOLLOW     1
`define MFS_B_PROFILE    2
`define MFS_B_DUMP       3
`define MFS_B_INPOS      4
`define MFS_B_ACCEL      5
`define MFS_B_DECEL      6
`define MFS_B_SOFTLIM    7
`define MFS_B_TEMP       8
`define MFS_B_UVFAULT    9
`define MFS_B_UVLIVE     10
`define MFS_B_OVER_V     11
`define MFS_B_PHASE_I    12
`define MFS_B_SPEED      13
`define MFS_B_OVERRIDE   14
`define MFS_B_ENCODER    15
`define MFS_B_LEGACY     16
`define MFS_B_CTRL_SUP   17
`define MFS_ERR_MASK     32'h0002_bb8f
`define MFS_NOCLR_MASK   32'h0002_9000
`define MFS_C_CLEAR      0
`define MFS_C_VMODE      1
`define MFS_P_UVENABLE   0

// ************************************************************
// reset values and thresholds
// ************************************************************
`define MFS_RST_SETTLE   32'h0000_0003
`define MFS_RST_WINDOW   32'h0000_0064
`define MFS_RST_OVLIM    16'h01c2
`define MFS_RST_UVCUT    16'h0050
`define MFS_RST_SPDLIM   32'h0000_1000
`define MFS_CTRL_MIN_MV  16'h2ee0
`define MFS_UV_HYS_NUM   19'h5
`define MFS_UV_HYS_DEN   19'h4

// ************************************************************
// timing
// ************************************************************
`define MFS_CLK_NS       5
`define MFS_UV_HOLD_NS   1000000000
`define MFS_UV_HOLD_CYC  (`MFS_UV_HOLD_NS / `MFS_CLK_NS)
`define MFS_UV_TW        28
`define MFS_AVG_DEPTH    16

`endif

// file: mfs_pkg.sv
// types shared by the motor fault and status monitor
`include "mfs_defines.svh"
`default_nettype none

package mfs_pkg;
    // one sample of the controller measurements
    typedef struct packed {
        logic signed [31:0] position;
        logic signed [31:0] target_position;
        logic signed [31:0] measured_velocity;
        logic signed [31:0] target_velocity;
        logic signed [31:0] following_deviation;
        logic signed [31:0] profile_deviation;
        logic [15:0]        motor_thermal_energy;
        logic [15:0]        drive_temperature;
        logic [15:0]        bus_voltage;
        logic [15:0]        control_voltage_mv;
        logic               dump_resistor_hot;
    } mfs_meas_t;

    // software configuration
    typedef struct packed {
        logic               vel_mode;
        logic [15:0]        thermal_energy_limit;
        logic [31:0]        following_deviation_max;
        logic [31:0]        profile_deviation_max;
        logic [15:0]        temperature_limit;
        logic signed [31:0] plim_lo;
        logic signed [31:0] plim_hi;
        logic [31:0]        undervoltage_policy;
        logic [31:0]        position_tolerance_window;
        logic [15:0]        ov_limit;
        logic [15:0]        uv_cutoff;
        logic [31:0]        speed_limit;
        logic [31:0]        settle_sample_count;
    } mfs_cfg_t;
endpackage

`default_nettype wire

// file: mfs_sync.sv
// two-stage synchroniser for asynchronous fault pins
`default_nettype none

module mfs_sync #(
    parameter int N = 1
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst_n,
    // pins and synchronised copy
    input  wire logic [N-1:0] d,
    output logic      [N-1:0] q
);
    typedef struct packed {
        logic [N-1:0] s1;
        logic [N-1:0] s2;
    } mfs_sync_t;

    mfs_sync_t st;
    mfs_sync_t next_st;

    // first stage feeds only the second
    always_comb begin
        next_st.s1 = d;
        next_st.s2 = st.s1;
    end

    // register the state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign q = st.s2;
endmodule

`default_nettype wire

// file: mfs_speed_avg.sv
// running average of speed magnitude over a window of samples
`default_nettype none

module mfs_speed_avg #(
    parameter int W     = 32,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                rst_n,
    // sample input
    input  wire logic                sample,
    input  wire logic signed [W-1:0] vel,
    // average of magnitudes
    output logic             [W-1:0] avg
);
    localparam int LG = $clog2(DEPTH);

    typedef struct packed {
        logic [LG-1:0]  ptr;
        logic [W+LG-1:0] sum;
    } mfs_avg_t;

    mfs_avg_t       st;
    mfs_avg_t       next_st;
    logic [W-1:0]   hist [DEPTH];
    logic [W-1:0]   mag;

    // replace the oldest magnitude in the running sum
    always_comb begin
        mag     = vel[W-1] ? W'(-vel) : W'(vel);
        next_st = st;
        if (sample) begin
            next_st.ptr = LG'(st.ptr + 1'b1);
            next_st.sum = st.sum - (W+LG)'(hist[st.ptr]) + (W+LG)'(mag);
        end
    end

    // register the state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // sample history, cleared so the first sums are honest
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < DEPTH; i++) begin
                hist[i] <= '0;
            end
        end else if (sample) begin
            hist[st.ptr] <= mag;
        end
    end

    assign avg = W'(st.sum >> LG);
endmodule

`default_nettype wire

// file: mfs_plant.sv
// measurement channel model that feeds samples to the monitor
`default_nettype none

module mfs_plant
    import mfs_pkg::*;
(
    // clock and reset
    input  wire logic      clk,
    input  wire logic      rst_n,
    // requested sample
    input  wire logic      go,
    input  wire mfs_meas_t want,
    // sample stream towards the monitor
    output logic           sample,
    output mfs_meas_t      meas
);
    timeunit 1ns;
    timeprecision 1ps;

    // one-cycle strobe; values follow the channel continuously, as the bus voltage does
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sample <= 1'b0;
            meas   <= '0;
        end else begin
            sample <= go;
            meas   <= want;
        end
    end
endmodule

`default_nettype wire

// file: motor_fault_status_monitor_test.sv
// self-checking bench for the motor fault and status monitor
`default_nettype none

module motor_fault_status_monitor_test;
    timeunit 1ns;
    timeprecision 1ps;
    import mfs_pkg::*;
    logic        CLOCK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SAMPLE, FAULT, e, go;
    logic        AC_MISSING, PHASE_OVERCURRENT, ENCODER_FAULT, MOTION_INHIBIT, vm;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA, STATUS, q, expv, seed;
    mfs_meas_t   MEAS, want;
    int          errors, checks, cyc, lim, n, pv;

    mfs_monitor #(.UV_HOLD_CYC(20), .AVG_DEPTH(16)) u_mfs_monitor (.CLOCK(CLOCK),
        .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
        .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SAMPLE(SAMPLE),
        .MEAS(MEAS), .AC_MISSING(AC_MISSING), .PHASE_OVERCURRENT(PHASE_OVERCURRENT),
        .ENCODER_FAULT(ENCODER_FAULT), .STATUS(STATUS), .FAULT(FAULT),
        .MOTION_INHIBIT(MOTION_INHIBIT));
    mfs_plant u_mfs_plant (.clk(CLOCK), .rst_n(RESETN), .go(go), .want(want),
        .sample(SAMPLE), .meas(MEAS));

    // clock and hang guard
    initial begin
        CLOCK = 1'b0;
        forever #2.5 CLOCK = ~CLOCK;
    end
    always @(posedge CLOCK) begin
        cyc++;
        if (cyc == 3000) begin
            errors++;
            finish_test();
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // apb transfer: hold everything until pready is seen at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        PSEL    <= 1'b1;
        PWRITE  <= w;
        PADDR   <= a;
        PWDATA  <= d;
        @(posedge CLOCK);
        PENABLE <= 1'b1;
        do begin
            @(posedge CLOCK);
        end while (PREADY !== 1'b1);
        q = PRDATA;
        e = PSLVERR;
        PSEL    <= 1'b0;
        PENABLE <= 1'b0;
        // one idle cycle so two calls never drive the strobes twice in one step
        @(posedge CLOCK);
    endtask

    // one sample through the channel model, then the reference status is compared
    task automatic smp(input int pos, input int vel);
        int a;
        a = vm ? vel : pos;
        want.position            <= pos;
        want.measured_velocity   <= vel;
        want.following_deviation <= xs();
        go <= 1'b1;
        @(posedge CLOCK);
        go <= 1'b0;
        repeat (3) @(posedge CLOCK);
        n = (a < 100 && a > -100) ? n + 1 : 0;
        expv[4] = (n >= 3);
        expv[5] = vel < pv;
        expv[6] = vel > pv;
        pv = vel;
        // both soft limits stay at zero, so any nonzero position is outside
        expv[14] = expv[14] && pos != 0;
        if (want.motor_thermal_energy > lim) expv[0] = 1'b1;
        chk(STATUS & 32'h0001_5073, expv);
    endtask

    task automatic finish_test();
        $display("errors=%0d checks=%0d", errors, checks);
        if (errors == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {RESETN, PSEL, PENABLE, PWRITE, go, AC_MISSING, PHASE_OVERCURRENT, ENCODER_FAULT} = '0;
        {PADDR, PWDATA, expv, want, vm} = '0;
        seed = 32'hcdae9f76;
        repeat (3) @(posedge CLOCK);
        RESETN <= 1'b1;
        apb(1'b0, 12'h088, '0);
        chk(q, 32'h3);
        apb(1'b0, 12'h3fc, '0);
        chk({31'h0, e}, 32'h1);
        lim = int'(xs() & 32'hff);
        apb(1'b1, 12'h044, 32'(lim));
        want.motor_thermal_energy <= 16'(lim + 1);
        smp(500, 40);
        chk({31'h0, MOTION_INHIBIT}, 32'h1);
        apb(1'b1, 12'h08c, 32'h0000_4000);
        expv[14] = 1'b1;
        chk({31'h0, MOTION_INHIBIT}, 32'h0);
        chk(STATUS & 32'h0001_5073, expv);
        want.motor_thermal_energy <= '0;
        smp(0, -20);
        smp(0, -10);
        smp(0, -10);
        apb(1'b1, 12'h040, 32'h1);
        expv[0] = 1'b0;
        smp(0, 30);
        PHASE_OVERCURRENT <= 1'b1;
        repeat (4) @(posedge CLOCK);
        PHASE_OVERCURRENT <= 1'b0;
        expv[12] = 1'b1;
        apb(1'b1, 12'h040, 32'h1);
        smp(0, 30);
        chk({31'h0, FAULT}, 32'h1);
        apb(1'b0, 12'h08c, '0);
        chk(q & 32'h0001_5073, expv);
        // velocity mode: the settle condition follows velocity, not position
        vm = 1'b1;
        apb(1'b1, 12'h040, 32'h2);
        apb(1'b0, 12'h040, '0);
        chk(q, 32'h2);
        smp(0, 300);
        repeat (3) smp(500, 7);
        finish_test();
    end
endmodule

`default_nettype wire
